// ===== verilog/match_capture_timer.sv
// Counter/timer with prescaler, four match units, two match pins and one capture input.
//
// Contract
// - The narrow build has a 16-bit counter behind a programmable 16-bit prescaler.
// - The wide build has a 32-bit counter, prescaler and match values.
// - Four match values are compared with the count, each optionally raising a flag.
// - Each match can halt counting when reached.
// - Each match can clear the counter back to zero when reached.
// - Two match pins go low, high, toggle or hold on their match.
// - Two matches can drive single-edge PWM on their pins.
// - All logic runs on the one system clock, sys_clk.
// - A capture input transition latches the count and may raise a flag.
//
// Usage notes.
// The counter steps once every prescale_limit+1 running cycles.
// A limit lowered below the live prescale value lets the prescaler run on to its own wrap,
// so change the limit while count_reset is held.
// A match is taken only on a counting step, so a counter parked on a match value by a halt
// or a disable does not raise the same event again and again.
// A stop match still applies the step on which it hits, so the count rests one above the
// stop value unless a reset match hits in the same step.
// The halt is released by dropping count_enable or by raising count_reset.
// A PWM pin compares the next count, so its edge lines up with the count on count_reg.
// For a clean PWM period, let an unpinned match reset the counter and keep the pinned
// matches for the waveform edges only.
// Flags are sticky, and an event in the same cycle as its clear wins, so no event is lost
// to a clear that arrives late.
// The capture input must already be synchronous to sys_clk; a pin from outside the chip
// needs a synchroniser ahead of this block.
`timescale 1ns/1ns
`default_nettype none
`include "match_capture_timer_defs.svh"
module match_capture_timer
    import match_capture_timer_pkg::*;
#(
    parameter int W = `MCT_WIDE_W // Set to the narrow width for the narrow build.
) (
    input  wire logic                         sys_clk,
    input  wire logic                         nrst,
    input  wire logic                         count_enable,
    input  wire logic                         count_reset,
    input  wire logic [W-1:0]                 prescale_limit,
    input  wire logic [`MCT_NUM_MATCH*W-1:0]  match_value,
    input  wire logic [`MCT_NUM_MATCH-1:0]    match_irq_en,
    input  wire logic [`MCT_NUM_MATCH-1:0]    match_stop_en,
    input  wire logic [`MCT_NUM_MATCH-1:0]    match_reset_en,
    input  wire logic [2*`MCT_NUM_PINS-1:0]   match_pin_action,
    input  wire logic [`MCT_NUM_PINS-1:0]     pwm_enable,
    input  wire logic                         cap_in,
    input  wire cap_edge_t                    cap_edge,
    input  wire logic                         cap_irq_en,
    input  wire logic [`MCT_NUM_FLAGS-1:0]    flag_clear,
    output var  logic [W-1:0]                 count_reg,
    output var  logic [W-1:0]                 prescale_reg,
    output var  logic [W-1:0]                 cap_value_reg,
    output var  logic [`MCT_NUM_FLAGS-1:0]    flag_reg,
    output var  logic [`MCT_NUM_PINS-1:0]     match_pin_reg,
    output var  logic                         halted_reg
);
    logic [W-1:0]               cap_value;
    logic                       cap_event;
    logic [`MCT_NUM_MATCH-1:0]  hit;
    logic [`MCT_NUM_PINS-1:0]   pin_next;

    // Prescale wrap gives the one-cycle step enable for the counter.
    wire run       = count_enable & ~halted_reg & ~count_reset;
    wire tick      = run & (prescale_reg == prescale_limit);
    wire any_reset = |(hit & match_reset_en);
    wire any_stop  = |(hit & match_stop_en);
    wire [W-1:0] prescale_next = (count_reset | tick) ? '0 : (run ? prescale_reg + 1'b1
                                                                     : prescale_reg);
    wire [W-1:0] count_next = count_reset ? '0 :
                              (tick ? (any_reset ? '0 : count_reg + 1'b1) : count_reg);

    // Match compare per unit; a hit is taken only on a counting step.
    genvar i;
    generate
        for (i = 0; i < `MCT_NUM_MATCH; i++) begin : g_match
            assign hit[i] = tick & (count_reg == match_value[i*W +: W]);
        end
        for (i = 0; i < `MCT_NUM_PINS; i++) begin : g_pin
            wire [1:0] act = match_pin_action[2*i +: 2];
            // In PWM mode the pin is low until its match and high after it.
            wire pwm_lvl = (count_next >= match_value[i*W +: W]);
            assign pin_next[i] = pwm_enable[i] ? pwm_lvl :
                                 !hit[i] ? match_pin_reg[i] :
                                 (act == `MCT_ACT_LOW)    ? 1'b0 :
                                 (act == `MCT_ACT_HIGH)   ? 1'b1 :
                                 (act == `MCT_ACT_TOGGLE) ? ~match_pin_reg[i] :
                                 match_pin_reg[i];
        end
    endgenerate

    // Flags: a new event wins over a clear in the same cycle.
    wire [`MCT_NUM_FLAGS-1:0] flag_set = {cap_event & cap_irq_en, hit & match_irq_en};
    wire [`MCT_NUM_FLAGS-1:0] flag_next = flag_set | (flag_reg & ~flag_clear);
    // A stop match halts the counter until the enable is dropped or a reset is applied.
    wire halted_next = count_reset ? 1'b0 : (any_stop | (halted_reg & count_enable));

    edge_capture #(
        .W(W)
    ) u_capture (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .cap_in    (cap_in),
        .cap_edge  (cap_edge),
        .count     (count_reg),
        .cap_value (cap_value),
        .cap_event (cap_event)
    );

    // Main state registers.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg     <= '0;
            prescale_reg  <= '0;
            cap_value_reg <= '0;
            flag_reg      <= '0;
            match_pin_reg <= '0;
            halted_reg    <= 1'b0;
        end else begin
            count_reg     <= count_next;
            prescale_reg  <= prescale_next;
            cap_value_reg <= cap_value;
            flag_reg      <= flag_next;
            match_pin_reg <= pin_next;
            halted_reg    <= halted_next;
        end
    end

    // Prescaler and step checks.
    a_prescale_step: assert property (@(posedge sys_clk) disable iff (!nrst)
        (run && prescale_reg != prescale_limit && !any_reset) |=> count_reg == $past(count_reg))
        else $error("counter stepped before prescale wrap");
    a_count_step: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tick && !any_reset) |=> count_reg == $past(count_reg) + 1'b1)
        else $error("counter missed its step");
    a_prescale_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
        tick |=> prescale_reg == '0)
        else $error("prescaler did not restart after its wrap");
    a_prescale_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!run && !count_reset) |=> prescale_reg == $past(prescale_reg))
        else $error("prescaler moved while not running");
    a_reset_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        count_reset |=> (count_reg == '0 && prescale_reg == '0 && !halted_reg))
        else $error("count reset did not clear the counter");

    // Reset and stop matches; a count reset right after a stop may legally move the count.
    a_match_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tick && any_reset) |=> count_reg == '0)
        else $error("reset match did not clear counter");
    a_match_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
        (any_stop && !count_reset) |=> halted_reg
            ##1 ($past(count_reset) || count_reg == $past(count_reg)))
        else $error("stop match did not halt");
    a_halt_freeze: assert property (@(posedge sys_clk) disable iff (!nrst)
        (halted_reg && !count_reset) |=> count_reg == $past(count_reg))
        else $error("halted counter moved");
    a_halt_release: assert property (@(posedge sys_clk) disable iff (!nrst)
        (halted_reg && !count_enable) |=> !halted_reg)
        else $error("halt not released by dropping the enable");
    a_stop_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hit[1] && match_irq_en[1]) |=> flag_reg[1])
        else $error("stop match flag not set");

    // Event flags.
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
        (flag_reg[0] && !flag_clear[0]) |=> flag_reg[0])
        else $error("flag dropped without clear");
    a_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hit[0] && match_irq_en[0]) |=> flag_reg[0])
        else $error("match flag not set");
    a_flag_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        (flag_clear[0] && !(hit[0] && match_irq_en[0])) |=> !flag_reg[0])
        else $error("flag not cleared by its clear bit");
    a_flag_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!flag_reg[0] && !(hit[0] && match_irq_en[0])) |=> !flag_reg[0])
        else $error("flag set without an event");
    a_cap_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        (cap_event && cap_irq_en) |=> flag_reg[`MCT_CAP_FLAG])
        else $error("capture flag not set");
    a_cap_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
        (flag_reg[`MCT_CAP_FLAG] && !flag_clear[`MCT_CAP_FLAG]) |=> flag_reg[`MCT_CAP_FLAG])
        else $error("capture flag dropped without clear");

    // Match pins in plain and PWM mode.
    a_pin_toggle: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hit[0] && !pwm_enable[0] && match_pin_action[1:0] == `MCT_ACT_TOGGLE)
        |=> match_pin_reg[0] != $past(match_pin_reg[0]))
        else $error("pin did not toggle");
    a_pin1_toggle: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hit[1] && !pwm_enable[1] && match_pin_action[3:2] == `MCT_ACT_TOGGLE)
        |=> match_pin_reg[1] != $past(match_pin_reg[1]))
        else $error("second pin did not toggle");
    a_pin_low: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hit[0] && !pwm_enable[0] && match_pin_action[1:0] == `MCT_ACT_LOW) |=> !match_pin_reg[0])
        else $error("pin not driven low on match");
    a_pin_high: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hit[0] && !pwm_enable[0] && match_pin_action[1:0] == `MCT_ACT_HIGH) |=> match_pin_reg[0])
        else $error("pin not driven high on match");
    a_pin_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!hit[0] && !pwm_enable[0]) |=> match_pin_reg[0] == $past(match_pin_reg[0]))
        else $error("pin moved without a match");
    a_pwm_level0: assert property (@(posedge sys_clk) disable iff (!nrst)
        pwm_enable[0] |=> match_pin_reg[0] == (count_reg >= $past(match_value[W-1:0])))
        else $error("first pwm level wrong");
    a_pwm_level: assert property (@(posedge sys_clk) disable iff (!nrst)
        pwm_enable[1] |=> match_pin_reg[1] == (count_reg >= $past(match_value[2*W-1:W])))
        else $error("pwm level wrong");

    // Main scenarios that the bench is expected to reach.
    c_reset_match: cover property (@(posedge sys_clk) disable iff (!nrst) tick && any_reset);
    c_stop_match: cover property (@(posedge sys_clk) disable iff (!nrst) any_stop);
    c_capture: cover property (@(posedge sys_clk) disable iff (!nrst) cap_event);
    c_pwm_rise: cover property (@(posedge sys_clk) disable iff (!nrst)
        pwm_enable[0] && $rose(match_pin_reg[0]));
    c_flag_clear: cover property (@(posedge sys_clk) disable iff (!nrst)
        flag_reg[0] && flag_clear[0]);
endmodule : match_capture_timer
`default_nettype wire

// ===== verilog/match_capture_timer_defs.svh
// Constants for the match and capture counter/timer.
`ifndef MATCH_CAPTURE_TIMER_DEFS_SVH
`define MATCH_CAPTURE_TIMER_DEFS_SVH
`define MCT_NARROW_W   16
`define MCT_WIDE_W     32
`define MCT_NUM_MATCH  4
`define MCT_NUM_PINS   2
`define MCT_NUM_FLAGS  5
`define MCT_CAP_FLAG   4
`define MCT_ACT_NONE   2'h0
`define MCT_ACT_LOW    2'h1
`define MCT_ACT_HIGH   2'h2
`define MCT_ACT_TOGGLE 2'h3
`endif

// ===== verilog/match_capture_timer_pkg.sv
// Types shared by the match and capture counter/timer.
package match_capture_timer_pkg;
    typedef enum logic [1:0] {
        cap_off,
        cap_rise,
        cap_fall,
        cap_both
    } cap_edge_t;
endpackage : match_capture_timer_pkg

// ===== verilog/edge_capture.sv
// Capture-input edge detector that latches the count on a selected transition.
`timescale 1ns/1ns
`default_nettype none
`include "match_capture_timer_defs.svh"
module edge_capture
    import match_capture_timer_pkg::*;
#(
    parameter int W = `MCT_WIDE_W
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         cap_in,
    input  wire cap_edge_t    cap_edge,
    input  wire logic [W-1:0] count,
    output var  logic [W-1:0] cap_value,
    output var  logic         cap_event
);
    logic prev_reg;
    wire  rise_hit = cap_in & ~prev_reg;
    wire  fall_hit = ~cap_in & prev_reg;
    // Selection of which transitions count as an event.
    wire  hit = ((cap_edge == cap_rise) & rise_hit) | ((cap_edge == cap_fall) & fall_hit)
              | ((cap_edge == cap_both) & (rise_hit | fall_hit));

    // The input is taken as synchronous, so one register serves as the edge history.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg  <= 1'b0;
            cap_value <= '0;
            cap_event <= 1'b0;
        end else begin
            prev_reg  <= cap_in;
            cap_event <= hit;
            if (hit) begin
                cap_value <= count;
            end
        end
    end

    a_cap_latch: assert property (@(posedge sys_clk) disable iff (!nrst)
        hit |=> (cap_event && cap_value == $past(count)))
        else $error("capture did not latch the count");
endmodule : edge_capture
`default_nettype wire

// ===== sim/cap_source.sv
// Model of the external signal source that drives the capture input.
`timescale 1ns/1ns
`default_nettype none
module cap_source (
    input  wire logic sys_clk,
    input  wire logic fire,
    output var  logic cap_in
);
    logic [1:0] hold_reg = 2'h0;

    // A request gives one clean high pulse of two cycles, so a rising and a falling
    // transition both reach the block; between requests the line rests low.
    always_ff @(posedge sys_clk) begin
        if (fire) begin
            hold_reg <= 2'h2;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end
    end
    assign cap_in = (hold_reg != 2'h0);
endmodule : cap_source
`default_nettype wire

// ===== sim/test_match_capture_timer.sv
// Self-checking testbench for the narrow build of the counter/timer.
`timescale 1ns/1ns
`default_nettype none
`include "match_capture_timer_defs.svh"
module test_match_capture_timer;
    import match_capture_timer_pkg::*;
    localparam int W = `MCT_NARROW_W;
    logic sys_clk = 1'b0, nrst = 1'b0, count_enable = 1'b0, count_reset = 1'b0;
    logic [W-1:0] prescale_limit = 16'h0000, count_reg, prescale_reg, cap_value_reg, c;
    logic [4*W-1:0] match_value = 64'h0;
    logic [3:0] match_irq_en = 4'h0, match_stop_en = 4'h0, match_reset_en = 4'h0;
    logic [3:0] match_pin_action = 4'h0;
    logic [1:0] pwm_enable = 2'h0, match_pin_reg;
    logic [4:0] flag_clear = 5'h00, flag_reg;
    logic cap_in, cap_irq_en = 1'b0, fire = 1'b0, halted_reg, hi, lo, hi1, lo1;
    cap_edge_t cap_edge = cap_off;
    int errors = 0, total_checks = 0, cycles = 0;

    match_capture_timer #(.W(W)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .count_enable(count_enable), .count_reset(count_reset),
        .prescale_limit(prescale_limit), .match_value(match_value),
        .match_irq_en(match_irq_en), .match_stop_en(match_stop_en),
        .match_reset_en(match_reset_en), .match_pin_action(match_pin_action),
        .pwm_enable(pwm_enable), .cap_in(cap_in), .cap_edge(cap_edge),
        .cap_irq_en(cap_irq_en), .flag_clear(flag_clear), .count_reg(count_reg),
        .prescale_reg(prescale_reg), .cap_value_reg(cap_value_reg),
        .flag_reg(flag_reg), .match_pin_reg(match_pin_reg), .halted_reg(halted_reg));
    cap_source src (.sys_clk(sys_clk), .fire(fire), .cap_in(cap_in));

    // Clock at 250 MHz; the cycle ceiling cuts a hang far beyond the expected run.
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Inputs move just after a rising edge; outputs are read at the falling edge.
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : step

    initial begin
        step(2);
        nrst <= 1'b1;
        step(1);
        @(negedge sys_clk);
        chk(count_reg, 16'h0000);
        chk({flag_reg, match_pin_reg, halted_reg}, 16'h0000);
        step(1);
        count_enable <= 1'b1;
        step(3);
        @(negedge sys_clk);
        c = count_reg;
        step(3);
        @(negedge sys_clk);
        chk(count_reg, c + 16'h0003);
        step(1);
        prescale_limit <= 16'h0002;
        step(2);
        @(negedge sys_clk);
        c = count_reg;
        chk(prescale_reg, 16'h0002);
        step(6);
        @(negedge sys_clk);
        chk(count_reg, c + 16'h0002);
        // Match 0 wraps the count at 5, raises its flag and sets pin 0.
        step(1);
        {prescale_limit, count_reset, match_reset_en, match_irq_en} <= {16'h0000, 9'h111};
        match_value[0 +: W] <= 16'h0005;
        match_pin_action <= {`MCT_ACT_NONE, `MCT_ACT_HIGH};
        step(1);
        count_reset <= 1'b0;
        step(20);
        @(negedge sys_clk);
        chk(16'(count_reg <= 16'h0005), 16'h0001);
        chk(16'(flag_reg[0]), 16'h0001);
        chk(16'(match_pin_reg[0]), 16'h0001);
        step(1);
        {match_irq_en, flag_clear} <= 9'h001;
        match_pin_action <= {`MCT_ACT_NONE, `MCT_ACT_LOW};
        step(8);
        flag_clear <= 5'h00;
        step(1);
        @(negedge sys_clk);
        chk(16'(match_pin_reg[0]), 16'h0000);
        chk(16'(flag_reg[0]), 16'h0000);
        // Match 1 at 7 halts the count, which then stands at 8.
        step(1);
        {match_reset_en, match_stop_en, count_reset} <= 9'h005;
        match_irq_en <= 4'h2;
        match_value[W +: W] <= 16'h0007;
        step(1);
        count_reset <= 1'b0;
        step(20);
        @(negedge sys_clk);
        chk(16'(halted_reg), 16'h0001);
        chk(16'(flag_reg[1]), 16'h0001);
        c = count_reg;
        step(3);
        @(negedge sys_clk);
        chk(count_reg, c);
        // A rising capture edge latches the frozen count and raises flag 4.
        step(1);
        {count_enable, cap_irq_en} <= 2'h1;
        cap_edge <= cap_rise;
        step(1);
        fire <= 1'b1;
        step(1);
        fire <= 1'b0;
        step(4);
        @(negedge sys_clk);
        chk(cap_value_reg, c);
        chk(16'(flag_reg[4]), 16'h0001);
        // Pin 0 in PWM with the period set by unpinned match 2.
        step(1);
        {match_stop_en, match_reset_en, pwm_enable, count_reset} <= 11'h023;
        match_pin_action <= {`MCT_ACT_TOGGLE, `MCT_ACT_NONE};
        match_value[2*W +: W] <= 16'h0009;
        match_value[0 +: W] <= 16'h0003;
        count_enable <= 1'b1;
        step(1);
        count_reset <= 1'b0;
        {hi, lo, hi1, lo1} = 4'h0;
        repeat (30) begin
            @(negedge sys_clk);
            hi |= (match_pin_reg[0] === 1'b1);
            lo |= (match_pin_reg[0] === 1'b0);
            hi1 |= (match_pin_reg[1] === 1'b1);
            lo1 |= (match_pin_reg[1] === 1'b0);
        end
        chk(16'({hi, lo}), 16'h0003);
        chk(16'({hi1, lo1}), 16'h0003);
        // A falling capture edge raises flag 4 again after it was cleared.
        step(1);
        flag_clear <= 5'h10;
        cap_edge <= cap_fall;
        step(1);
        flag_clear <= 5'h00;
        @(negedge sys_clk);
        chk(16'(flag_reg[4]), 16'h0000);
        step(1);
        fire <= 1'b1;
        step(1);
        fire <= 1'b0;
        step(6);
        @(negedge sys_clk);
        chk(16'(flag_reg[4]), 16'h0001);
        wrap_up();
    end
endmodule : test_match_capture_timer
`default_nettype wire
